// >>> rtl/two_wire_slave_pkg.sv
// package: constants, states and carriers of the two-wire slave bit layer
package two_wire_slave_pkg;

  // power-up wait the master keeps before its first command, in microseconds
  localparam int POWER_UP_COMMAND_WAIT_US = 100;
  // least supply-off time between power cycles, in milliseconds
  localparam int POWER_CYCLE_OFF_TIME_MS = 500;

  localparam int BYTE_BITS = 8;
  // bit index of the acknowledge slot, the ninth clock of a byte
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // bit index of the last data bit, the eighth clock of a byte
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] FIRST_BIT = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // link-side states, one-hot
  typedef enum logic [2:0] {
    LINK_STANDBY = 3'b001,
    LINK_ACTIVE = 3'b010,
    LINK_WRITE_WAIT = 3'b100
  } link_state_t;

  // single-cycle bus events seen on the link clock
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
  } bus_event_t;

  // event toggles travelling from the link side to the system side
  typedef struct packed {
    logic start;
    logic stop;
    logic rx;
    logic nack;
    logic tx_taken;
  } link_toggle_t;

  // controls travelling from the system side to the link side
  typedef struct packed {
    logic tx_load;
    logic write_done;
    logic ack_en;
    logic tx_mode;
    logic write_arm;
  } sys_ctrl_t;

endpackage : two_wire_slave_pkg

// >>> rtl/two_wire_slave_bit_layer.sv
// two-wire slave bit and byte layer with link-clock oversampling front end
module two_wire_slave_bit_layer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic ack_en_i,
  input wire logic tx_mode_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_load_i,
  input wire logic write_arm_i,
  input wire logic write_done_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic start_o,
  output logic stop_o,
  output logic nack_o,
  output logic tx_taken_o,
  output logic active_o
);

  // ---------------- system-side reset and control ----------------
  logic [1:0] rst_sync;
  logic rst_n;
  logic [1:0] link_rst_sync;
  logic link_rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // the link side holds the bus released until this copy lets go
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_rst_sync <= 2'h0;
    end else begin
      link_rst_sync <= {link_rst_sync[0], 1'b1};
    end
  end
  assign link_rst_n = link_rst_sync[1];

  two_wire_slave_pkg::sys_ctrl_t ctrl;
  logic [7:0] tx_word;

  // tx_word stays put after a load, so the link side may copy it whenever
  // the load toggle arrives without a word-wide synchroniser
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
      tx_word <= two_wire_slave_pkg::BYTE_RESET;
    end else begin
      ctrl.ack_en <= ack_en_i;
      ctrl.tx_mode <= tx_mode_i;
      ctrl.write_arm <= write_arm_i;
      if (tx_load_i) begin
        ctrl.tx_load <= ~ctrl.tx_load;
        tx_word <= tx_data_i;
      end
      if (write_done_i) begin
        ctrl.write_done <= ~ctrl.write_done;
      end
    end
  end

  // ---------------- link side ----------------
  two_wire_slave_pkg::sys_ctrl_t ctrl_m;
  two_wire_slave_pkg::sys_ctrl_t ctrl_s;
  two_wire_slave_pkg::sys_ctrl_t ctrl_d;

  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ctrl_m <= '0;
      ctrl_s <= '0;
      ctrl_d <= '0;
    end else begin
      ctrl_m <= ctrl;
      ctrl_s <= ctrl_m;
      ctrl_d <= ctrl_s;
    end
  end

  // idle-high reset keeps a spurious edge off the first cycles
  logic [1:0] scl_q;
  logic [1:0] sda_q;
  logic scl_d;
  logic sda_d;

  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      scl_q <= 2'h3;
      sda_q <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_q <= {scl_q[0], scl_i};
      sda_q <= {sda_q[0], sda_i};
      scl_d <= scl_q[1];
      sda_d <= sda_q[1];
    end
  end

  two_wire_slave_pkg::bus_event_t ev;
  logic scl;
  logic sda;
  assign scl = scl_q[1];
  assign sda = sda_q[1];

  always_comb begin
    ev.scl_rise = scl & ~scl_d;
    ev.scl_fall = ~scl & scl_d;
    // data may only move under a steady high clock for Start or Stop
    ev.start = scl & scl_d & sda_d & ~sda;
    ev.stop = scl & scl_d & ~sda_d & sda;
  end

  two_wire_slave_pkg::link_state_t state;
  two_wire_slave_pkg::link_toggle_t tgl;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic rose;
  logic tx_byte;
  logic nacked;
  logic [7:0] rx_shift;
  logic [7:0] rx_byte;
  logic [7:0] tx_shift;
  logic [7:0] tx_hold;
  logic tx_fresh;

  assign next_bit_cnt = (bit_cnt == two_wire_slave_pkg::ACK_SLOT) ?
                        two_wire_slave_pkg::FIRST_BIT :
                        bit_cnt + 4'h1;

  // word handed over by the system side
  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_hold <= two_wire_slave_pkg::BYTE_RESET;
      tx_fresh <= 1'b0;
    end else if (ctrl_s.tx_load != ctrl_d.tx_load) begin
      tx_hold <= tx_word;
      tx_fresh <= 1'b1;
    end else if (ev.scl_fall && rose && tx_byte == 1'b0 &&
                 next_bit_cnt == two_wire_slave_pkg::FIRST_BIT &&
                 ctrl_s.tx_mode) begin
      tx_fresh <= 1'b0;
    end else if (ev.scl_fall && rose && tx_byte &&
                 next_bit_cnt == two_wire_slave_pkg::FIRST_BIT) begin
      tx_fresh <= 1'b0;
    end
  end

  // state: standby, active transfer, or waiting out an internal write
  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state <= two_wire_slave_pkg::LINK_STANDBY;
    end else begin
      case (state)
        two_wire_slave_pkg::LINK_STANDBY: begin
          if (ev.start) begin
            state <= two_wire_slave_pkg::LINK_ACTIVE;
          end
        end
        two_wire_slave_pkg::LINK_ACTIVE: begin
          if (ev.stop) begin
            state <= ctrl_s.write_arm ?
                     two_wire_slave_pkg::LINK_WRITE_WAIT :
                     two_wire_slave_pkg::LINK_STANDBY;
          end
        end
        two_wire_slave_pkg::LINK_WRITE_WAIT: begin
          // bus is deaf until the memory reports the write finished
          if (ctrl_s.write_done != ctrl_d.write_done) begin
            state <= two_wire_slave_pkg::LINK_STANDBY;
          end
        end
        default: begin
          state <= two_wire_slave_pkg::LINK_STANDBY;
        end
      endcase
    end
  end

  logic in_xfer;
  assign in_xfer = (state == two_wire_slave_pkg::LINK_ACTIVE) &&
                   !ev.start && !ev.stop;

  // bit counting, shifting and the data-line drive
  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt <= two_wire_slave_pkg::FIRST_BIT;
      rose <= 1'b0;
      tx_byte <= 1'b0;
      nacked <= 1'b0;
      rx_shift <= two_wire_slave_pkg::BYTE_RESET;
      rx_byte <= two_wire_slave_pkg::BYTE_RESET;
      tx_shift <= two_wire_slave_pkg::BYTE_RESET;
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
      tgl <= '0;
    end else begin
      sda_o <= 1'b0;
      if ((ev.start || ev.stop) && state != 
          two_wire_slave_pkg::LINK_WRITE_WAIT) begin
        // a repeated Start restarts framing the same way a first one does
        bit_cnt <= two_wire_slave_pkg::FIRST_BIT;
        rose <= 1'b0;
        tx_byte <= 1'b0;
        nacked <= 1'b0;
        sda_oe_o <= 1'b0;
        if (ev.start) begin
          tgl.start <= ~tgl.start;
        end else if (state == two_wire_slave_pkg::LINK_ACTIVE) begin
          tgl.stop <= ~tgl.stop;
        end
      end else if (in_xfer && ev.scl_rise) begin
        rose <= 1'b1;
        if (bit_cnt == two_wire_slave_pkg::ACK_SLOT) begin
          if (tx_byte && sda) begin
            nacked <= 1'b1;
            tgl.nack <= ~tgl.nack;
          end
        end else begin
          rx_shift <= {rx_shift[6:0], sda};
          if (bit_cnt == two_wire_slave_pkg::LAST_DATA_BIT && !tx_byte) begin
            rx_byte <= {rx_shift[6:0], sda};
            tgl.rx <= ~tgl.rx;
          end
        end
      end else if (in_xfer && ev.scl_fall && rose) begin
        rose <= 1'b0;
        bit_cnt <= next_bit_cnt;
        if (next_bit_cnt == two_wire_slave_pkg::ACK_SLOT) begin
          // transmitter lets go; receiver pulls low for the ninth clock when ack_en is set
          sda_oe_o <= !tx_byte && ctrl_s.ack_en;
        end else if (next_bit_cnt == two_wire_slave_pkg::FIRST_BIT) begin
          // next byte goes out only when a word is waiting and no NACK
          if (ctrl_s.tx_mode && tx_fresh && !nacked) begin
            tx_byte <= 1'b1;
            tx_shift <= {tx_hold[6:0], 1'b0};
            sda_oe_o <= ~tx_hold[7];
            tgl.tx_taken <= ~tgl.tx_taken;
          end else begin
            tx_byte <= 1'b0;
            sda_oe_o <= 1'b0;
          end
        end else if (tx_byte) begin
          sda_oe_o <= ~tx_shift[7];
          tx_shift <= {tx_shift[6:0], 1'b0};
        end else begin
          sda_oe_o <= 1'b0;
        end
      end else if (state != two_wire_slave_pkg::LINK_ACTIVE) begin
        sda_oe_o <= 1'b0;
      end
    end
  end
  // holds because the drive only moves right after a clock fall
  // and detection of Start/Stop needs two high clock samples

  logic active_link;
  assign active_link = (state != two_wire_slave_pkg::LINK_STANDBY);

  // ---------------- back to the system side ----------------
  two_wire_slave_pkg::link_toggle_t tgl_m;
  two_wire_slave_pkg::link_toggle_t tgl_s;
  two_wire_slave_pkg::link_toggle_t tgl_d;
  logic [1:0] active_q;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tgl_m <= '0;
      tgl_s <= '0;
      tgl_d <= '0;
      active_q <= 2'h0;
    end else begin
      tgl_m <= tgl;
      tgl_s <= tgl_m;
      tgl_d <= tgl_s;
      active_q <= {active_q[0], active_link};
    end
  end

  // rx_byte is stable for a whole byte time after its toggle flips
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_o <= two_wire_slave_pkg::BYTE_RESET;
      rx_valid_o <= 1'b0;
      start_o <= 1'b0;
      stop_o <= 1'b0;
      nack_o <= 1'b0;
      tx_taken_o <= 1'b0;
      active_o <= 1'b0;
    end else begin
      rx_valid_o <= tgl_s.rx ^ tgl_d.rx;
      if (tgl_s.rx ^ tgl_d.rx) begin
        rx_data_o <= rx_byte;
      end
      start_o <= tgl_s.start ^ tgl_d.start;
      stop_o <= tgl_s.stop ^ tgl_d.stop;
      nack_o <= tgl_s.nack ^ tgl_d.nack;
      tx_taken_o <= tgl_s.tx_taken ^ tgl_d.tx_taken;
      active_o <= active_q[1];
    end
  end

endmodule : two_wire_slave_bit_layer

// >>> verif/two_wire_slave_sva.sv
// checker: port timing of the two-wire slave bit layer
module two_wire_slave_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic write_arm_i,
  input wire logic [7:0] rx_data_o,
  input wire logic rx_valid_o,
  input wire logic start_o,
  input wire logic stop_o,
  input wire logic active_o
);
  timeunit 1ns;
  timeprecision 1ps;
  sequence s_wake;
    ##[0:6] active_o;
  endsequence
  sequence s_sleep;
    ##[0:6] !active_o;
  endsequence
  sequence s_deaf;
    ##1 active_o [*8];
  endsequence
  drive_low_only_a: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i) sda_oe_o |-> !sda_o)
    else $error("data line driven high");
  // the answer lags the fall by the synchroniser, so scl is still low
  oe_moves_low_a: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i) $changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed while clock high");
  reset_quiet_a: assert property (
    @(posedge clk_i) !rst_n_i |-> !sda_oe_o && !active_o)
    else $error("outputs live during reset");
  start_pulse_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) start_o |=> !start_o && !stop_o)
    else $error("start event longer than one cycle");
  rx_hold_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) $changed(rx_data_o) |-> rx_valid_o)
    else $error("received byte changed without valid");
  start_wakes_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) start_o |-> s_wake)
    else $error("start did not leave standby");
  stop_sleeps_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) stop_o && !write_arm_i |-> s_sleep)
    else $error("stop did not return to standby");
  write_wait_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) stop_o && write_arm_i |-> s_deaf)
    else $error("standby entered before write cycle end");
endmodule : two_wire_slave_sva

// >>> verif/two_wire_master_model.sv
// model: bus master that drives the clock and pulls the data line low
module two_wire_master_model (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = 100;
  // idle bus: clock high, data left to the pull-up
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic start_cond();
    sda_low_o = 1'b0;
    #(H) scl_o = 1'b1;
    #(H) sda_low_o = 1'b1;
    #(H) scl_o = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    sda_low_o = 1'b1;
    #(H) scl_o = 1'b1;
    #(H) sda_low_o = 1'b0;
    #(H);
  endtask : stop_cond
  // data moves only in the low phase; no pause inside a byte
  task automatic clock_bit(input logic b, output logic seen);
    #(H / 2) sda_low_o = !b;
    #(H / 2) scl_o = 1'b1;
    #(H / 2) seen = sda_i;
    #(H / 2) scl_o = 1'b0;
  endtask : clock_bit
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
    clock_bit(1'b1, s);
    ack = !s;
  endtask : send_byte
  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, d[i]);
    clock_bit(nack, s);
    sda_low_o = 1'b0;
  endtask : recv_byte
  task automatic dummy_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      #(H) scl_o = 1'b0;
      #(H) scl_o = 1'b1;
    end
  endtask : dummy_clocks
endmodule : two_wire_master_model

// >>> verif/two_wire_slave_bit_layer_bench.sv
// bench: two-wire slave bit layer against a behavioural bus master
module two_wire_slave_bit_layer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_n_i, link_clk_i = 1'b0;
  logic ack_en_i = 1'b0, tx_mode_i = 1'b0, tx_load_i = 1'b0;
  logic write_arm_i = 1'b0, write_done_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic scl, sda_low, sda, sda_o, sda_oe_o, rx_valid_o, start_o, stop_o;
  logic nack_o, tx_taken_o, active_o, ack;
  logic [7:0] rx_data_o, d, n_rx = 8'h00, n_start = 8'h00, n_stop = 8'h00;
  logic [7:0] n_nack = 8'h00, n_tx = 8'h00;
  int mismatches = 0, compares = 0;
  always #10 clk_i = ~clk_i;
  // odd start offset keeps the link clock out of phase with clk_i
  initial begin
    #1.7;
    forever #3 link_clk_i = ~link_clk_i;
  end
  assign sda = (sda_low || (sda_oe_o && !sda_o)) ? 1'b0 : 1'b1;
  always @(posedge clk_i) begin
    n_rx <= n_rx + 8'(rx_valid_o);
    n_start <= n_start + 8'(start_o);
    n_stop <= n_stop + 8'(stop_o);
    n_nack <= n_nack + 8'(nack_o);
    n_tx <= n_tx + 8'(tx_taken_o);
  end
  two_wire_master_model i_m (.sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  two_wire_slave_bit_layer i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .ack_en_i(ack_en_i), .tx_mode_i(tx_mode_i), .tx_data_i(tx_data_i),
    .tx_load_i(tx_load_i), .write_arm_i(write_arm_i),
    .write_done_i(write_done_i), .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o), .start_o(start_o), .stop_o(stop_o),
    .nack_o(nack_o), .tx_taken_o(tx_taken_o), .active_o(active_o));
  task automatic end_sim();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [7:0] exp, got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_active(input logic exp);
    for (int i = 0; i < 50 && active_o !== exp; i++) @(negedge clk_i);
    chk("active", 8'(exp), 8'(active_o));
    if (active_o !== exp) end_sim();
  endtask : wait_active
  task automatic pulse(input logic [7:0] w, input logic done);
    @(negedge clk_i);
    tx_data_i = w;
    tx_load_i = !done;
    write_done_i = done;
    @(negedge clk_i);
    tx_load_i = 1'b0;
    write_done_i = 1'b0;
  endtask : pulse
  task automatic t_write();
    @(negedge clk_i) ack_en_i = 1'b1;
    i_m.start_cond();
    i_m.send_byte(8'hA5, ack);
    chk("ack", 8'h01, 8'(ack));
    chk("rx byte", 8'hA5, rx_data_o);
    chk("starts", 8'h01, n_start);
    wait_active(1'b1);
    @(negedge clk_i) ack_en_i = 1'b0;
    i_m.send_byte(8'h3C, ack);
    chk("nack", 8'h00, 8'(ack));
    chk("rx byte", 8'h3C, rx_data_o);
    i_m.stop_cond();
    wait_active(1'b0);
    // the stop counter lags the output register by one clock
    @(negedge clk_i);
    chk("stops", 8'h01, n_stop);
  endtask : t_write
  task automatic t_read();
    @(negedge clk_i) ack_en_i = 1'b1;
    tx_mode_i = 1'b1;
    i_m.start_cond();
    fork
      i_m.send_byte(8'hA1, ack);
      begin
        repeat (20) @(posedge clk_i);
        pulse(8'h96, 1'b0);
      end
    join
    i_m.recv_byte(1'b1, d);
    chk("tx byte", 8'h96, d);
    chk("taken", 8'h01, n_tx);
    chk("nacks", 8'h01, n_nack);
    chk("released", 8'h00, 8'(sda_oe_o));
    chk("drive level", 8'h00, 8'(sda_o));
    @(negedge clk_i) tx_mode_i = 1'b0;
    i_m.start_cond();
    i_m.send_byte(8'h42, ack);
    chk("rx byte", 8'h42, rx_data_o);
    chk("starts", 8'h03, n_start);
    i_m.stop_cond();
    wait_active(1'b0);
  endtask : t_read
  // a stop with a write armed leaves the device deaf until write_done
  task automatic t_write_wait();
    @(negedge clk_i) write_arm_i = 1'b1;
    i_m.start_cond();
    i_m.send_byte(8'h11, ack);
    i_m.stop_cond();
    repeat (20) @(posedge clk_i);
    chk("active", 8'h01, 8'(active_o));
    i_m.start_cond();
    i_m.send_byte(8'h22, ack);
    chk("deaf ack", 8'h00, 8'(ack));
    chk("rx count", 8'h05, n_rx);
    @(negedge clk_i) write_arm_i = 1'b0;
    pulse(8'h00, 1'b1);
    wait_active(1'b0);
    i_m.stop_cond();
    chk("stops", 8'h03, n_stop);
  endtask : t_write_wait
  initial begin
    // a real falling edge so every asynchronous reset fires before clocks
    #1 rst_n_i = 1'b0;
    // bus clocks run on through reset and release and must be ignored
    fork
      i_m.dummy_clocks(4);
      repeat (6) @(posedge clk_i);
    join_any
    @(negedge clk_i) rst_n_i = 1'b1;
    #(two_wire_slave_pkg::POWER_UP_COMMAND_WAIT_US * 1000);
    i_m.dummy_clocks(9);
    chk("starts", 8'h00, n_start);
    chk("rx count", 8'h00, n_rx);
    t_write();
    t_read();
    t_write_wait();
    end_sim();
  end
  initial begin
    #1000000;
    mismatches++;
    end_sim();
  end
endmodule : two_wire_slave_bit_layer_bench
bind two_wire_slave_bit_layer two_wire_slave_sva i_sva (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i),
  .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .write_arm_i(write_arm_i), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
  .start_o(start_o), .stop_o(stop_o), .active_o(active_o));
